// file: hdl/pvi_sink.sv
// video input block: per-port capture with frame store, and top level
module pvi_port_rx
   import pvi_pkg::*;
#(
   parameter int XW = 5,
   parameter int YW = 5
)
(
   input wire logic sys_clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic pclk, // synchronised pixel clock
   input wire logic fsync, // synchronised frame sync
   input wire logic lsync, // synchronised line sync
   input wire logic pvalid, // synchronised pixel valid
   input wire pvi_bus_t bus, // synchronised colour buses
   input wire logic [MAP_W-1:0] chan_map, // source group per colour
   input wire logic rd_en, // frame store read request
   input wire logic [YW+XW-1:0] rd_addr, // {line, column}
   input wire logic ovf_clr, // clears overflow flag
   output pvi_pixel_t rd_data, // displayed pixel
   output logic rd_valid, // rd_data updated
   output logic frame_update, // pulse per received frame
   output logic frame_repeat, // pulse when last frame repeats
   output logic overflow // sticky, a word was lost
);
   localparam int WW = 1 + YW + XW + PIXEL_W;
   logic pclk_d, fs_d, ls_d, next_pclk_d, next_fs_d, next_ls_d;
   logic [XW-1:0] x, next_x;
   logic [YW-1:0] y, next_y;
   logic push, in_ready, out_valid, pop;
   logic [WW-1:0] push_word, out_word;
   logic disp_bank, got_pix, next_disp_bank, next_got_pix;
   logic next_frame_update, next_frame_repeat, next_overflow, next_rd_valid;
   logic edge_seen, fs_rise, ls_rise;
   pvi_pixel_t pix, store [2**(YW+XW+1)];

   function automatic logic [COLOUR_W-1:0] pick(pvi_bus_t b, logic [1:0] sel);
      logic [COLOUR_W-1:0] c;
      c = '0;
      if (sel == 2'h0)
      begin
         c = b[CHAN_W-1 -: COLOUR_W];
      end
      else if (sel == 2'h1)
      begin
         c = b[2*CHAN_W-1 -: COLOUR_W];
      end
      else if (sel == 2'h2)
      begin
         c = b[3*CHAN_W-1 -: COLOUR_W];
      end
      return c;
   endfunction

   // upper 8 bits of each 10-bit group, groups steered by map
   assign pix = {pick(bus, chan_map[5:4]), pick(bus, chan_map[3:2]),
                 pick(bus, chan_map[1:0])};
   assign edge_seen = pclk && !pclk_d;
   assign fs_rise = edge_seen && fsync && !fs_d;
   assign ls_rise = edge_seen && lsync && !ls_d;
   // frame markers travel through the fifo to keep them in order with pixels
   assign push = fs_rise || (edge_seen && pvalid);
   assign push_word = {fs_rise, y, x, pix};
   // reads win the single store port; the fifo absorbs the stall
   assign pop = out_valid && !rd_en;

   pvi_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .in_valid(push),
      .in_ready(in_ready),
      .in_data(push_word),
      .out_valid(out_valid),
      .out_ready(!rd_en),
      .out_data(out_word)
   );

   always_comb
   begin
      next_pclk_d = pclk;
      next_fs_d = edge_seen ? fsync : fs_d;
      next_ls_d = edge_seen ? lsync : ls_d;
      next_x = x;
      next_y = y;
      if (fs_rise)
      begin
         next_x = '0;
         next_y = '1;
      end
      else if (ls_rise)
      begin
         next_x = '0;
         next_y = y + 1'b1;
      end
      else if (edge_seen && pvalid)
      begin
         next_x = x + 1'b1;
      end
      next_disp_bank = disp_bank;
      next_got_pix = got_pix;
      next_frame_update = 1'b0;
      next_frame_repeat = 1'b0;
      if (pop && out_word[WW-1])
      begin
         next_frame_update = 1'b1;
         next_got_pix = 1'b0;
         if (got_pix)
         begin
            next_disp_bank = ~disp_bank;
         end
         else
         begin
            next_frame_repeat = 1'b1;
         end
      end
      else if (pop)
      begin
         next_got_pix = 1'b1;
      end
      next_overflow = (overflow && !ovf_clr) || (push && !in_ready);
      next_rd_valid = rd_en;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pclk_d <= 1'b0;
         fs_d <= 1'b0;
         ls_d <= 1'b0;
         x <= '0;
         y <= '0;
         disp_bank <= 1'b0;
         got_pix <= 1'b0;
         frame_update <= 1'b0;
         frame_repeat <= 1'b0;
         overflow <= 1'b0;
         rd_valid <= 1'b0;
      end
      else
      begin
         pclk_d <= next_pclk_d;
         fs_d <= next_fs_d;
         ls_d <= next_ls_d;
         x <= next_x;
         y <= next_y;
         disp_bank <= next_disp_bank;
         got_pix <= next_got_pix;
         frame_update <= next_frame_update;
         frame_repeat <= next_frame_repeat;
         overflow <= next_overflow;
         rd_valid <= next_rd_valid;
      end
   end

   // two banks: fill one while the other is shown
   always_ff @(posedge sys_clk)
   begin
      if (pop && !out_word[WW-1])
      begin
         store[{~disp_bank, out_word[WW-2:PIXEL_W]}] <= out_word[PIXEL_W-1:0];
      end
      if (rd_en)
      begin
         rd_data <= store[{disp_bank, rd_addr}];
      end
   end
endmodule

module pvi_sink
   import pvi_pkg::*;
#(
   parameter int XW = 5,
   parameter int YW = 5
)
(
   input wire logic sys_clk, // system clock
   input wire logic nrst, // async reset, active low
   pvi_link_if.sink link, // video link
   input wire logic [NUM_PORTS-1:0][MAP_W-1:0] chan_map, // colour group map per port
   input wire logic port2_use_spare, // port 2 samples on spare clock
   input wire logic pattern_mode, // video-driven pattern mode
   input wire logic [NUM_PORTS-1:0] rd_en, // frame store read per port
   input wire logic [NUM_PORTS-1:0][YW+XW-1:0] rd_addr, // read address per port
   input wire logic [NUM_PORTS-1:0] ovf_clr, // overflow clear per port
   output pvi_pixel_t [NUM_PORTS-1:0] rd_data, // displayed pixel per port
   output logic [NUM_PORTS-1:0] rd_valid, // read answer per port
   output logic [NUM_PORTS-1:0] frame_update, // new or repeated frame shown
   output logic [NUM_PORTS-1:0] frame_repeat, // last frame repeated
   output logic [NUM_PORTS-1:0] overflow, // sticky lost word
   output logic pattern_start // pulse starting a pattern sequence
);
   localparam int SW = 2 * (BUS_W + 4) + 1;
   logic [SW-1:0] meta, sync, raw;
   logic next_pattern_start;
   logic [NUM_PORTS-1:0] pclk, fs, ls, dv;
   pvi_bus_t bus [NUM_PORTS];

   assign raw = {link.spare_pixel_clock,
                 link.port2_pixel_clock, link.port2_frame_sync, link.port2_line_sync,
                 link.port2_pixel_valid, link.port2_colour_buses,
                 link.port1_pixel_clock, link.port1_frame_sync, link.port1_line_sync,
                 link.port1_pixel_valid, link.port1_colour_buses};

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta <= '0;
         sync <= '0;
         pattern_start <= 1'b0;
      end
      else
      begin
         meta <= raw;
         sync <= meta;
         pattern_start <= next_pattern_start;
      end
   end

   assign next_pattern_start = pattern_mode && frame_update[0];
   assign {pclk[0], fs[0], ls[0], dv[0], bus[0]} = sync[BUS_W+3:0];
   assign {fs[1], ls[1], dv[1], bus[1]} = sync[2*BUS_W+6:BUS_W+4];
   // spare clock may stand in for port 2's own clock
   assign pclk[1] = port2_use_spare ? sync[SW-1] : sync[SW-2];

   for (genvar p = 0; p < NUM_PORTS; p++)
   begin : g_port
      pvi_port_rx #(.XW(XW), .YW(YW)) u_rx
      (
         .sys_clk(sys_clk),
         .nrst(nrst),
         .pclk(pclk[p]),
         .fsync(fs[p]),
         .lsync(ls[p]),
         .pvalid(dv[p]),
         .bus(bus[p]),
         .chan_map(chan_map[p]),
         .rd_en(rd_en[p]),
         .rd_addr(rd_addr[p]),
         .ovf_clr(ovf_clr[p]),
         .rd_data(rd_data[p]),
         .rd_valid(rd_valid[p]),
         .frame_update(frame_update[p]),
         .frame_repeat(frame_repeat[p]),
         .overflow(overflow[p])
      );
   end
endmodule

// file: hdl/pvi_pkg.sv
// shared constants and types for the dual parallel video input link
package pvi_pkg;
   localparam int SYS_CLK_NS = 10;
   localparam int PCLK_PERIOD_NS = 160;
   localparam int PCLK_HALF_CYC = PCLK_PERIOD_NS / (2 * SYS_CLK_NS);
   localparam int NUM_PORTS = 2;
   localparam int CHAN_W = 10;
   localparam int COLOUR_W = 8;
   localparam int PIXEL_W = 24;
   localparam int BUS_W = 3 * CHAN_W;
   localparam int COLOUR_LSB = CHAN_W - COLOUR_W;
   localparam int MAP_W = 6;
   localparam logic [5:0] MAP_RESET = 6'h24;
   localparam int FIFO_DEPTH = 16;
   typedef logic [BUS_W-1:0] pvi_bus_t;
   typedef logic [PIXEL_W-1:0] pvi_pixel_t;
endpackage

// file: hdl/pvi_link_if.sv
// link wires between the video source and the video input block
interface pvi_link_if;
   import pvi_pkg::*;
   logic port1_pixel_clock;
   logic port2_pixel_clock;
   logic spare_pixel_clock;
   logic port1_frame_sync;
   logic port1_line_sync;
   logic port1_pixel_valid;
   pvi_bus_t port1_colour_buses;
   logic port2_frame_sync;
   logic port2_line_sync;
   logic port2_pixel_valid;
   pvi_bus_t port2_colour_buses;
   modport source
   (
      output port1_pixel_clock, port2_pixel_clock, spare_pixel_clock,
      output port1_frame_sync, port1_line_sync, port1_pixel_valid, port1_colour_buses,
      output port2_frame_sync, port2_line_sync, port2_pixel_valid, port2_colour_buses
   );
   modport sink
   (
      input port1_pixel_clock, port2_pixel_clock, spare_pixel_clock,
      input port1_frame_sync, port1_line_sync, port1_pixel_valid, port1_colour_buses,
      input port2_frame_sync, port2_line_sync, port2_pixel_valid, port2_colour_buses
   );
endinterface

// file: hdl/pvi_source.sv
// video source end: pixel clock divider, frame timing, pixel launch; shared fifo
module pvi_source
   import pvi_pkg::*;
#(
   parameter int H_TOTAL = 24,
   parameter int H_START = 4,
   parameter int H_ACTIVE = 16,
   parameter int V_TOTAL = 8,
   parameter int V_START = 2,
   parameter int V_ACTIVE = 4,
   parameter int SYNC_LEN = 2
)
(
   input wire logic sys_clk, // system clock
   input wire logic nrst, // async reset, active low
   pvi_link_if.source link, // video link
   input wire logic frame_req, // send an image in the next frame
   input wire pvi_pixel_t pix_data, // pixel at req_x, req_y
   output logic [7:0] req_x, // column of next pixel
   output logic [7:0] req_y, // line of next pixel
   output logic frame_busy // current frame carries an image
);
   localparam int CW = $clog2(PCLK_HALF_CYC + 1);
   logic [CW-1:0] div_cnt, next_div_cnt;
   logic [7:0] h, v, next_h, next_v, next_req_x, next_req_y;
   logic pclk, next_pclk, launch, active, next_busy;
   logic fs, ls, dv1, dv2, next_fs, next_ls, next_dv1, next_dv2;
   pvi_bus_t bus1, bus2, next_bus1, next_bus2, word;

   // outputs change as the clock falls so the rising edge finds them stable
   assign launch = pclk && (div_cnt == CW'(PCLK_HALF_CYC - 1));
   assign active = frame_busy && (h >= 8'(H_START)) && (h < 8'(H_START + H_ACTIVE))
                   && (v >= 8'(V_START)) && (v < 8'(V_START + V_ACTIVE));
   assign word = {pix_data[23:16], 2'h0, pix_data[15:8], 2'h0,
                  pix_data[7:0], 2'h0};

   always_comb
   begin
      next_div_cnt = (div_cnt == CW'(PCLK_HALF_CYC - 1)) ? '0 : div_cnt + 1'b1;
      next_pclk = (div_cnt == CW'(PCLK_HALF_CYC - 1)) ? ~pclk : pclk;
      next_h = h;
      next_v = v;
      next_busy = frame_busy;
      next_fs = fs;
      next_ls = ls;
      next_dv1 = dv1;
      next_dv2 = dv2;
      next_bus1 = bus1;
      next_bus2 = bus2;
      if (launch)
      begin
         next_fs = (v == 8'h00);
         next_ls = (h < 8'(SYNC_LEN));
         // first half of each line on port 1, second half on port 2
         next_dv1 = active && (h < 8'(H_START + H_ACTIVE / 2));
         next_dv2 = active && (h >= 8'(H_START + H_ACTIVE / 2));
         next_bus1 = next_dv1 ? word : '0;
         next_bus2 = next_dv2 ? word : '0;
         next_h = (h == 8'(H_TOTAL - 1)) ? 8'h00 : h + 8'h01;
         if (h == 8'(H_TOTAL - 1))
         begin
            next_v = (v == 8'(V_TOTAL - 1)) ? 8'h00 : v + 8'h01;
            if (v == 8'(V_TOTAL - 1))
            begin
               next_busy = frame_req;
            end
         end
      end
      next_req_x = next_h - 8'(H_START);
      next_req_y = next_v - 8'(V_START);
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         div_cnt <= '0;
         pclk <= 1'b0;
         h <= '0;
         v <= '0;
         frame_busy <= 1'b0;
         fs <= 1'b0;
         ls <= 1'b0;
         dv1 <= 1'b0;
         dv2 <= 1'b0;
         bus1 <= '0;
         bus2 <= '0;
         req_x <= '0;
         req_y <= '0;
      end
      else
      begin
         div_cnt <= next_div_cnt;
         pclk <= next_pclk;
         h <= next_h;
         v <= next_v;
         frame_busy <= next_busy;
         fs <= next_fs;
         ls <= next_ls;
         dv1 <= next_dv1;
         dv2 <= next_dv2;
         bus1 <= next_bus1;
         bus2 <= next_bus2;
         req_x <= next_req_x;
         req_y <= next_req_y;
      end
   end

   assign link.port1_pixel_clock = pclk;
   assign link.port2_pixel_clock = pclk;
   assign link.spare_pixel_clock = pclk;
   assign link.port1_frame_sync = fs;
   assign link.port2_frame_sync = fs;
   assign link.port1_line_sync = ls;
   assign link.port2_line_sync = ls;
   assign link.port1_pixel_valid = dv1;
   assign link.port2_pixel_valid = dv2;
   assign link.port1_colour_buses = bus1;
   assign link.port2_colour_buses = bus2;
endmodule

// fall-through fifo used by the capture side of the link
module pvi_fifo
   import pvi_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic sys_clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic in_valid, // write request
   output logic in_ready, // room for a word
   input wire logic [WIDTH-1:0] in_data, // word written
   output logic out_valid, // word available
   input wire logic out_ready, // reader takes word
   output logic [WIDTH-1:0] out_data // oldest word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic full, empty;

   assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty = (wr_ptr == rd_ptr);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem[rd_ptr[AW-1:0]];

   always_comb
   begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (in_valid && !full)
      begin
         next_wr_ptr = wr_ptr + 1'b1;
      end
      if (out_ready && !empty)
      begin
         next_rd_ptr = rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (in_valid && !full)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule

// file: dv/pvi_asserts.sv
// wire checks on the link between the video source and the video input
module pvi_asserts
   import pvi_pkg::*;
#(
   parameter int H_TOTAL = 24,
   parameter int V_TOTAL = 8
)
(
   input wire logic sys_clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic port1_pixel_clock, // port 1 pixel clock
   input wire logic port2_pixel_clock, // port 2 pixel clock
   input wire logic spare_pixel_clock, // spare pixel clock
   input wire logic port1_frame_sync, // port 1 frame sync
   input wire logic port1_line_sync, // port 1 line sync
   input wire logic port1_pixel_valid, // port 1 pixel valid
   input wire pvi_bus_t port1_colour_buses, // port 1 colour groups
   input wire logic port2_frame_sync, // port 2 frame sync
   input wire logic port2_line_sync, // port 2 line sync
   input wire logic port2_pixel_valid, // port 2 pixel valid
   input wire pvi_bus_t port2_colour_buses // port 2 colour groups
);
   localparam int LINE_CYC = H_TOTAL * 2 * PCLK_HALF_CYC;
   localparam int FRAME_CYC = LINE_CYC * V_TOTAL;
   logic fs_d, next_fs_d, seen, next_seen, fs_rise;
   logic [15:0] fcnt, next_fcnt;
   assign fs_rise = port1_frame_sync && !fs_d;
   // frame period is too long for a repetition, so count it
   always_comb
   begin
      next_fs_d = port1_frame_sync;
      next_seen = seen || fs_rise;
      next_fcnt = fs_rise ? 16'h0000 : fcnt + 16'h0001;
   end
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fs_d <= 1'b0;
         seen <= 1'b0;
         fcnt <= 16'h0000;
      end
      else
      begin
         fs_d <= next_fs_d;
         seen <= next_seen;
         fcnt <= next_fcnt;
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   clk_high_a: assert property ($rose(port1_pixel_clock) |-> port1_pixel_clock [*8] ##1 !port1_pixel_clock)
      else $error("pixel clock high phase wrong");
   clk_low_a: assert property ($fell(port1_pixel_clock) |-> !port1_pixel_clock [*8] ##1 port1_pixel_clock)
      else $error("pixel clock low phase wrong");
   clk_same_a: assert property (port2_pixel_clock == port1_pixel_clock && spare_pixel_clock == port1_pixel_clock)
      else $error("pixel clocks differ");
   launch_hold_a: assert property (port1_pixel_clock |-> $stable({port1_frame_sync, port1_line_sync,
      port1_pixel_valid, port1_colour_buses, port2_frame_sync, port2_line_sync, port2_pixel_valid,
      port2_colour_buses})) else $error("link changed while pixel clock high");
   low_bits_a: assert property (port1_pixel_valid || port2_pixel_valid |->
      ((port1_colour_buses | port2_colour_buses) & 30'h00300c03) == 30'h0)
      else $error("unused low channel bits driven");
   line_period_a: assert property ($rose(port1_line_sync) |-> ##[LINE_CYC:LINE_CYC] $rose(port1_line_sync))
      else $error("line sync period wrong");
   frame_period_a: assert property (fs_rise && seen |-> fcnt == FRAME_CYC - 1)
      else $error("frame sync period wrong");
   frame_gap_a: assert property (fcnt < FRAME_CYC)
      else $error("frame sync missing");
   valid_window_a: assert property (port1_pixel_valid || port2_pixel_valid |->
      !port1_line_sync && !port1_frame_sync && !port2_line_sync && !port2_frame_sync)
      else $error("pixel valid during sync");
   port_excl_a: assert property (!(port1_pixel_valid && port2_pixel_valid))
      else $error("both ports valid at once");
   port_handoff_a: assert property ($fell(port1_pixel_valid) |-> port2_pixel_valid)
      else $error("port 2 did not take over the line");
endmodule

// file: dv/pvi_sink_tb.sv
// self-checking bench joining the video source end to the video input end
module pvi_sink_tb
   import pvi_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int H_TOTAL = 24;
   localparam int V_TOTAL = 8;
   localparam int V_START = 2;
   localparam int ROW_OFS = V_START - 1;
   localparam logic [7:0] XS [4] = '{8'h00, 8'h07, 8'h08, 8'h0f};
   logic sys_clk, nrst, port2_use_spare, pattern_mode, frame_req, frame_busy, pattern_start;
   logic [NUM_PORTS-1:0][MAP_W-1:0] chan_map;
   logic [NUM_PORTS-1:0] rd_en, ovf_clr, rd_valid, frame_update, frame_repeat, overflow;
   logic [NUM_PORTS-1:0][9:0] rd_addr;
   pvi_pixel_t [NUM_PORTS-1:0] rd_data;
   pvi_pixel_t pix_data;
   logic [7:0] req_x, req_y;
   logic [1:0] rep;
   int bad_count, n_checks, cyc;
   pvi_link_if link();
   pvi_source #(.H_TOTAL(H_TOTAL), .V_TOTAL(V_TOTAL), .V_START(V_START)) pvi_source_inst (
      .sys_clk(sys_clk), .nrst(nrst), .link(link), .frame_req(frame_req), .pix_data(pix_data),
      .req_x(req_x), .req_y(req_y), .frame_busy(frame_busy));
   pvi_sink pvi_sink_inst (.sys_clk(sys_clk), .nrst(nrst), .link(link), .chan_map(chan_map),
      .port2_use_spare(port2_use_spare), .pattern_mode(pattern_mode), .rd_en(rd_en),
      .rd_addr(rd_addr), .ovf_clr(ovf_clr), .rd_data(rd_data), .rd_valid(rd_valid),
      .frame_update(frame_update), .frame_repeat(frame_repeat), .overflow(overflow),
      .pattern_start(pattern_start));
   pvi_asserts #(.H_TOTAL(H_TOTAL), .V_TOTAL(V_TOTAL)) pvi_asserts_inst (.sys_clk(sys_clk),
      .nrst(nrst), .port1_pixel_clock(link.port1_pixel_clock),
      .port2_pixel_clock(link.port2_pixel_clock), .spare_pixel_clock(link.spare_pixel_clock),
      .port1_frame_sync(link.port1_frame_sync), .port1_line_sync(link.port1_line_sync),
      .port1_pixel_valid(link.port1_pixel_valid), .port1_colour_buses(link.port1_colour_buses),
      .port2_frame_sync(link.port2_frame_sync), .port2_line_sync(link.port2_line_sync),
      .port2_pixel_valid(link.port2_pixel_valid), .port2_colour_buses(link.port2_colour_buses));
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // each colour distinct so a wrong group mapping always shows
   function automatic pvi_pixel_t pix(input logic [7:0] x, input logic [7:0] y);
      return {x ^ y ^ 8'ha5, y + 8'h80, x + 8'h40};
   endfunction
   function automatic pvi_pixel_t remap(input pvi_pixel_t p, input logic [5:0] m);
      logic [3:0][7:0] g;
      g = {8'h00, p};
      return {g[m[5:4]], g[m[3:2]], g[m[1:0]]};
   endfunction
   always @(negedge sys_clk)
      pix_data <= pix(req_x, req_y);
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         bad_count++;
         close_out();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // pattern start is judged on every cycle while waiting
   task automatic wait_upd();
      logic [1:0] seen;
      logic prev;
      seen = 2'b00;
      prev = 1'b0;
      rep = 2'b00;
      for (int i = 0; i < 8000 && seen != 2'b11; i++)
      begin
         @(negedge sys_clk);
         check(pattern_start, prev && pattern_mode);
         prev = frame_update[0];
         rep = rep | (frame_update & frame_repeat & ~seen);
         seen = seen | frame_update;
      end
      @(negedge sys_clk);
      check(pattern_start, prev && pattern_mode);
      check(seen, 2'b11);
   endtask
   task automatic send_img(input logic stall);
      frame_req = 1'b1;
      for (int i = 0; i < 8000 && frame_busy !== 1'b1; i++)
         @(negedge sys_clk);
      frame_req = 1'b0;
      rd_en = {2{stall}};
      for (int i = 0; i < 8000 && frame_busy !== 1'b0; i++)
         @(negedge sys_clk);
      rd_en = 2'b00;
      check(overflow, {2{stall}});
      wait_upd();
   endtask
   // reads stay enabled back to back, lowered once at the end
   task automatic rd(input int p, input int y, input int x, input pvi_pixel_t exp);
      rd_en[p] = 1'b1;
      rd_addr[p] = {5'(y + ROW_OFS), 5'(x - 8 * p)};
      @(negedge sys_clk);
      check(rd_valid[p], 1'b1);
      check(rd_data[p], exp);
   endtask
   task automatic check_img(input logic [5:0] m0, input logic [5:0] m1);
      logic [7:0] x;
      logic [7:0] y;
      for (int i = 0; i < 8; i++)
      begin
         x = XS[i % 4];
         y = (i < 4) ? 8'h00 : 8'h03;
         rd(int'(x[3]), int'(y), int'(x), remap(pix(x, y), x[3] ? m1 : m0));
      end
      rd_en = 2'b00;
   endtask
   task automatic t_image();
      send_img(1'b0);
      check(rep, 2'b00);
      check_img(MAP_RESET, MAP_RESET);
      $display("test image done");
   endtask
   task automatic t_repeat();
      pattern_mode = 1'b1;
      wait_upd();
      check(rep, 2'b11);
      check_img(MAP_RESET, MAP_RESET);
      pattern_mode = 1'b0;
      $display("test repeat done");
   endtask
   task automatic t_overflow();
      send_img(1'b1);
      // the stalled start marker closes the blank frame before the image
      check(rep, 2'b11);
      ovf_clr = 2'b11;
      @(negedge sys_clk);
      ovf_clr = 2'b00;
      @(negedge sys_clk);
      check(overflow, 2'b00);
      $display("test overflow done");
   endtask
   task automatic t_map();
      chan_map = {6'h34, 6'h12};
      port2_use_spare = 1'b1;
      send_img(1'b0);
      check(rep, 2'b00);
      check_img(6'h12, 6'h34);
      $display("test channel map done");
   endtask
   initial
   begin
      nrst = 1'b0;
      chan_map = {MAP_RESET, MAP_RESET};
      port2_use_spare = 1'b0;
      pattern_mode = 1'b0;
      frame_req = 1'b0;
      rd_en = 2'b00;
      rd_addr = '0;
      ovf_clr = 2'b00;
      repeat (20) @(negedge sys_clk);
      nrst = 1'b1;
      t_image();
      t_repeat();
      t_overflow();
      t_map();
      close_out();
   end
endmodule
